// file: logic/reset_cause_pkg.sv
`default_nettype none
package reset_cause_pkg;
  // Byte addresses of the word-aligned registers
  localparam logic [3:0] ADDR_MAIN = 4'h0;
  localparam logic [3:0] ADDR_EXTRA = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  // Field positions in the main flag register
  localparam int BIT_STACK_OVER = 7;
  localparam int BIT_STACK_UNDER = 6;
  localparam int BIT_WINDOW = 5;
  localparam int BIT_WATCHDOG = 4;
  localparam int BIT_PIN = 3;
  localparam int BIT_SW = 2;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;
  // Field position in the extra flag register
  localparam int BIT_MEM_VIOL = 1;
  // Value after the very first power-up
  localparam logic [7:0] MAIN_POWER_UP = 8'h3c;
  localparam logic [7:0] EXTRA_IMPL_MASK = 8'h02;
  localparam int NUM_CAUSES = 9;
  localparam int CAUSE_MEM = 8;
  localparam logic [NUM_CAUSES-1:0] CAUSE_NONE = 9'h000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  // Bus slave phases
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;
endpackage
`default_nettype wire

// file: logic/reset_cause_flags.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`default_nettype none
module reset_cause_flags
  import reset_cause_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_on_i,
  input wire logic brownout_i,
  input wire logic stack_over_i,
  input wire logic stack_under_i,
  input wire logic watchdog_timeout_i,
  input wire logic pin_reset_i,
  input wire logic sw_reset_i,
  input wire logic mem_violation_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic window_armed_i,
  input wire logic window_open_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic window_violation_reset_o,
  output logic irq_o
);

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] readdata;
    logic [7:0] main_flags;
    logic mem_flag;
    logic [NUM_CAUSES-1:0] irq_status;
    logic [NUM_CAUSES-1:0] irq_mask;
    logic wv_reset;
    logic irq;
    logic waitreq;
  } state_t;

  state_t cur;
  state_t next_cur;

  // Register view, decoded for the read path only
  function automatic logic [31:0] read_mux(input logic [3:0] a,
                                           input state_t s);
    logic [31:0] r;
    r = UNMAPPED_READ;
    case (a)
      ADDR_MAIN: r = {24'h000000, s.main_flags};
      ADDR_EXTRA: r = {24'h000000,
                       6'h00, s.mem_flag, 1'b0};
      ADDR_IRQ_STATUS: r = {23'h000000, s.irq_status};
      ADDR_IRQ_MASK: r = {23'h000000, s.irq_mask};
      default: r = UNMAPPED_READ;
    endcase
    return r;
  endfunction

  logic wv_event;
  logic [NUM_CAUSES-1:0] causes;
  logic wr_take;

  // Cause strobes, bit index equals main flag bit; memory at index 8
  always_comb begin
    wv_event = watchdog_clear_instruction_i &&
               (!window_armed_i || !window_open_i);
    causes = CAUSE_NONE;
    causes[BIT_STACK_OVER] = stack_over_i;
    causes[BIT_STACK_UNDER] = stack_under_i;
    causes[BIT_WINDOW] = wv_event;
    causes[BIT_WATCHDOG] = watchdog_timeout_i;
    causes[BIT_PIN] = pin_reset_i;
    causes[BIT_SW] = sw_reset_i;
    causes[BIT_POWER_ON] = power_on_i;
    causes[BIT_BROWNOUT] = brownout_i;
    causes[CAUSE_MEM] = mem_violation_i;
    // Write lands only on the edge where waitrequest is seen low
    wr_take = avs_write_i && (cur.bus == BUS_DONE) && avs_byteenable_i[0];
  end

  // Next state: firmware write first, hardware causes override it
  always_comb begin
    next_cur = cur;
    next_cur.wv_reset = wv_event;
    // One wait cycle per access keeps read data registered
    case (cur.bus)
      BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          next_cur.bus = BUS_DONE;
          next_cur.readdata = read_mux(avs_address_i, cur);
        end
      end
      BUS_DONE: begin
        next_cur.bus = BUS_IDLE;
      end
      default: next_cur.bus = BUS_IDLE;
    endcase
    // Writes only store; they never raise any reset output
    if (wr_take) begin
      case (avs_address_i)
        ADDR_MAIN: next_cur.main_flags = avs_writedata_i[7:0];
        ADDR_EXTRA: next_cur.mem_flag = avs_writedata_i[BIT_MEM_VIOL];
        ADDR_IRQ_STATUS: next_cur.irq_status =
          cur.irq_status & ~avs_writedata_i[NUM_CAUSES-1:0];
        ADDR_IRQ_MASK: next_cur.irq_mask = avs_writedata_i[NUM_CAUSES-1:0];
        default: next_cur.irq_mask = cur.irq_mask;
      endcase
    end
    // Strobes applied on the clock; a strobe wins over a same-cycle write
    if (stack_over_i)
      next_cur.main_flags[BIT_STACK_OVER] = 1'b1;
    if (stack_under_i)
      next_cur.main_flags[BIT_STACK_UNDER] = 1'b1;
    if (wv_event)
      next_cur.main_flags[BIT_WINDOW] = 1'b0;
    if (watchdog_timeout_i)
      next_cur.main_flags[BIT_WATCHDOG] = 1'b0;
    if (pin_reset_i)
      next_cur.main_flags[BIT_PIN] = 1'b0;
    if (sw_reset_i)
      next_cur.main_flags[BIT_SW] = 1'b0;
    // Power loss also reloads the stack, window, watchdog, pin, sw and memory causes to their inactive look
    if (power_on_i)
      next_cur.main_flags = MAIN_POWER_UP;
    else if (brownout_i)
      next_cur.main_flags = {2'b00, 4'hf, cur.main_flags[BIT_POWER_ON],
                             1'b0};
    if (power_on_i || brownout_i)
      next_cur.mem_flag = 1'b1;
    else if (mem_violation_i)
      next_cur.mem_flag = 1'b0;
    // Sticky event bits; set beats the write-one clear
    next_cur.irq_status = next_cur.irq_status | causes;
    next_cur.irq = |(cur.irq_status & cur.irq_mask);
    // Registered so the bus output comes straight from a flop
    next_cur.waitreq = (next_cur.bus == BUS_IDLE);
  end

  // Flags survive rst_i; only power-on or brown-out reloads them
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cur.bus <= BUS_IDLE;
      cur.readdata <= UNMAPPED_READ;
      cur.irq_status <= CAUSE_NONE;
      cur.irq_mask <= CAUSE_NONE;
      cur.wv_reset <= 1'b0;
      cur.irq <= 1'b0;
      cur.waitreq <= 1'b1;
      cur.main_flags <= next_cur.main_flags;
      cur.mem_flag <= next_cur.mem_flag;
    end else begin
      cur <= next_cur;
    end
  end

  assign avs_readdata_o = cur.readdata;
  assign avs_waitrequest_o = cur.waitreq;
  assign window_violation_reset_o = cur.wv_reset;
  assign irq_o = cur.irq;

  // Helper: no write and no strobe in the current cycle
  logic quiet;
  assign quiet = !wr_take && (causes == CAUSE_NONE);

  AST_OVF_SET: assert property (@(posedge clock_i)
    stack_over_i && !power_on_i && !brownout_i
    |=> cur.main_flags[BIT_STACK_OVER])
    else $error("stack over flag not set");
  AST_UNF_SET: assert property (@(posedge clock_i)
    stack_under_i && !power_on_i && !brownout_i
    |=> cur.main_flags[BIT_STACK_UNDER])
    else $error("stack under flag not set");
  AST_WV_CLR: assert property (@(posedge clock_i)
    wv_event && !power_on_i && !brownout_i |=> !cur.main_flags[BIT_WINDOW])
    else $error("window flag not cleared");
  AST_WV_RST: assert property (@(posedge clock_i) disable iff (rst_i)
    watchdog_clear_instruction_i && window_armed_i && !window_open_i
    |=> window_violation_reset_o)
    else $error("window violation reset missing");
  AST_WDT_CLR: assert property (@(posedge clock_i)
    watchdog_timeout_i && !power_on_i && !brownout_i
    |=> !cur.main_flags[BIT_WATCHDOG])
    else $error("watchdog flag not cleared");
  AST_PIN_CLR: assert property (@(posedge clock_i)
    pin_reset_i && !power_on_i && !brownout_i |=> !cur.main_flags[BIT_PIN])
    else $error("pin flag not cleared");
  AST_SW_CLR: assert property (@(posedge clock_i)
    sw_reset_i && !power_on_i && !brownout_i |=> !cur.main_flags[BIT_SW])
    else $error("sw flag not cleared");
  AST_POR: assert property (@(posedge clock_i)
    power_on_i |=> cur.main_flags == MAIN_POWER_UP && cur.mem_flag)
    else $error("power-on load wrong");
  AST_BOR: assert property (@(posedge clock_i)
    brownout_i && !power_on_i |=> !cur.main_flags[BIT_BROWNOUT])
    else $error("brownout flag not cleared");
  AST_MEM_CLR: assert property (@(posedge clock_i)
    mem_violation_i && !power_on_i && !brownout_i |=> !cur.mem_flag)
    else $error("memory flag not cleared");
  AST_EXTRA_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
    cur.bus == BUS_DONE && $past(avs_address_i) == ADDR_EXTRA
    |-> (avs_readdata_o[7:0] & ~EXTRA_IMPL_MASK) == 8'h00)
    else $error("unimplemented bits not zero");
  AST_STABLE: assert property (@(posedge clock_i)
    quiet |=> $stable(cur.main_flags) && $stable(cur.mem_flag))
    else $error("flags changed without cause");
  AST_NO_RST: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_take && !watchdog_clear_instruction_i
    |=> !window_violation_reset_o)
    else $error("write raised a reset");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 irq_o == $past(|(cur.irq_status & cur.irq_mask)))
    else $error("irq level wrong");

  // A request seen while idle is answered in the very next cycle
  AST_WAIT_ANSWER: assert property (@(posedge clock_i)
    disable iff (rst_i) (avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("request not answered");

  // Waitrequest drops for one cycle only
  AST_WAIT_ONE: assert property (@(posedge clock_i)
    disable iff (rst_i) !avs_waitrequest_o
    |=> avs_waitrequest_o)
    else $error("waitrequest low too long");

  // No answer without a request
  AST_WAIT_IDLE: assert property (@(posedge clock_i)
    disable iff (rst_i) !avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o)
    else $error("answer without request");

  // A quiet write stores the byte as given
  AST_WR_MAIN: assert property (@(posedge clock_i)
    disable iff (rst_i) wr_take && avs_address_i == ADDR_MAIN
    && causes == CAUSE_NONE |=> cur.main_flags == $past(avs_writedata_i[7:0]))
    else $error("main write lost");

  // Firmware may put the memory flag either way
  AST_WR_EXTRA: assert property (@(posedge clock_i)
    disable iff (rst_i) wr_take && avs_address_i == ADDR_EXTRA
    && causes == CAUSE_NONE |=> cur.mem_flag == $past(avs_writedata_i[1]))
    else $error("extra write lost");

  // Power loss of either kind reloads the memory flag
  AST_MEM_LOAD: assert property (@(posedge clock_i)
    power_on_i || brownout_i
    |=> cur.mem_flag)
    else $error("memory flag not reloaded");

  // Brown-out reloads the upper causes and keeps the power-on bit
  AST_BOR_LOAD: assert property (@(posedge clock_i)
    brownout_i && !power_on_i |=> cur.main_flags[7:2] == MAIN_POWER_UP[7:2]
    && cur.main_flags[BIT_POWER_ON] == $past(cur.main_flags[BIT_POWER_ON]))
    else $error("brownout load wrong");

  // Active-high flags never fall back by themselves
  AST_KEEP_OVF: assert property (@(posedge clock_i)
    disable iff (rst_i) !wr_take && !power_on_i && !brownout_i
    && cur.main_flags[BIT_STACK_OVER] |=> cur.main_flags[BIT_STACK_OVER])
    else $error("overflow flag fell back");

  AST_KEEP_UNF: assert property (@(posedge clock_i)
    disable iff (rst_i) !wr_take && !power_on_i && !brownout_i
    && cur.main_flags[BIT_STACK_UNDER] |=> cur.main_flags[BIT_STACK_UNDER])
    else $error("underflow flag fell back");

  // Active-low flags stay low until firmware or power loss
  AST_KEEP_WV: assert property (@(posedge clock_i)
    disable iff (rst_i) !wr_take && !power_on_i && !brownout_i
    && !cur.main_flags[BIT_WINDOW] |=> !cur.main_flags[BIT_WINDOW])
    else $error("window flag fell back");

  AST_KEEP_WDT: assert property (@(posedge clock_i)
    disable iff (rst_i) !wr_take && !power_on_i && !brownout_i
    && !cur.main_flags[BIT_WATCHDOG] |=> !cur.main_flags[BIT_WATCHDOG])
    else $error("watchdog flag fell back");

  AST_KEEP_PIN: assert property (@(posedge clock_i)
    disable iff (rst_i) !wr_take && !power_on_i && !brownout_i
    && !cur.main_flags[BIT_PIN] |=> !cur.main_flags[BIT_PIN])
    else $error("pin flag fell back");

  AST_KEEP_SW: assert property (@(posedge clock_i)
    disable iff (rst_i) !wr_take && !power_on_i && !brownout_i
    && !cur.main_flags[BIT_SW] |=> !cur.main_flags[BIT_SW])
    else $error("sw flag fell back");

  // No watchdog clear, no violation pulse
  AST_WV_QUIET: assert property (@(posedge clock_i)
    disable iff (rst_i) !watchdog_clear_instruction_i
    |=> !window_violation_reset_o)
    else $error("spurious violation pulse");

  // A clear before arming is always a violation
  AST_WV_UNARMED: assert property (@(posedge clock_i)
    disable iff (rst_i) watchdog_clear_instruction_i && !window_armed_i
    |=> window_violation_reset_o)
    else $error("unarmed clear not caught");

  // Nothing above the widest register ever reads back
  AST_RD_HIGH_ZERO: assert property (@(posedge clock_i)
    disable iff (rst_i) !avs_waitrequest_o
    |-> avs_readdata_o[31:9] == 23'h000000)
    else $error("upper read bits not zero");

  // Each cause strobe leaves its sticky status bit set
  for (genvar g = 0; g < NUM_CAUSES; g++) begin : gen_status
    AST_STATUS_SET: assert property (@(posedge clock_i)
      disable iff (rst_i) causes[g]
      |=> cur.irq_status[g])
      else $error("status bit not set");
  end

  COV_POR: cover property (@(posedge clock_i) power_on_i);
  COV_WV: cover property (@(posedge clock_i) wv_event);
  COV_WR: cover property (@(posedge clock_i) wr_take ##2 avs_read_i);
  COV_IRQ: cover property (@(posedge clock_i) irq_o);
  COV_BOR: cover property (@(posedge clock_i) brownout_i);

endmodule
`default_nettype wire

// file: bench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import reset_cause_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [8:0] cause = 9'h000;
  logic wd_clear = 1'b0, armed = 1'b0, wopen = 1'b0;
  logic [3:0] addr = 4'h0, be = 4'hf;
  logic rd_en = 1'b0, wr_en = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic waitreq, wv_reset, irq_o;
  int err_count = 0, comparisons = 0, cycles = 0, wv_seen = 0, wv_exp = 0;
  logic [31:0] expq[$];
  logic [31:0] d;
  logic [7:0] main_m;
  logic extra_m;
  logic [8:0] stat_m;

  reset_cause_flags reset_cause_flags_inst (.clock_i(clock_i), .rst_i(rst_i),
    .power_on_i(cause[1]), .brownout_i(cause[0]), .stack_over_i(cause[7]),
    .stack_under_i(cause[6]), .watchdog_timeout_i(cause[4]),
    .pin_reset_i(cause[3]), .sw_reset_i(cause[2]),
    .mem_violation_i(cause[8]), .watchdog_clear_instruction_i(wd_clear),
    .window_armed_i(armed), .window_open_i(wopen), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .window_violation_reset_o(wv_reset),
    .irq_o(irq_o));

  // Free-running system clock
  always #12.5 clock_i = ~clock_i;

  task automatic compare_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compared, %0d bad", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One bus access; gap cycle after it keeps the two-cycle spacing
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                     input logic [3:0] lanes);
    addr <= a;
    wdata <= v;
    be <= lanes;
    if (w) wr_en <= 1'b1;
    else rd_en <= 1'b1;
    do @(posedge clock_i); while (waitreq !== 1'b0);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'hf);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic check_all();
    rd(ADDR_MAIN, {24'h0, main_m});
    rd(ADDR_EXTRA, {30'h0, extra_m, 1'b0});
    rd(ADDR_IRQ_STATUS, {23'h0, stat_m});
  endtask

  // Cause strobe, then the flag update the rules predict
  task automatic strobe(input int i);
    cause[i] <= 1'b1;
    @(posedge clock_i);
    cause[i] <= 1'b0;
    @(posedge clock_i);
    stat_m[i] = 1'b1;
    case (i)
      1: begin
        main_m = MAIN_POWER_UP;
        extra_m = 1'b1;
      end
      0: begin
        main_m = {6'h0f, main_m[1], 1'b0};
        extra_m = 1'b1;
      end
      7, 6: main_m[i] = 1'b1;
      8: extra_m = 1'b0;
      default: main_m[i] = 1'b0;
    endcase
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clock_i);
    compare_val("irq", {31'h0, e}, {31'h0, irq_o});
  endtask

  // Read answers are taken at the edge that sees waitrequest low
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (wv_reset === 1'b1) wv_seen++;
    if (rd_en === 1'b1 && waitreq === 1'b0) begin
      if (expq.size() == 0) compare_val("extra read", 32'h1, 32'h0);
      else compare_val("readdata", expq.pop_front(), rdata);
    end
    if (cycles > 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(70));
    // Power-on strobe from time zero so the flags are known from the first clock edge on
    strobe(1);
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    stat_m = 9'h000;
    check_all();
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(4'h2, UNMAPPED_READ);
    $display("test reset values done");
    // Firmware may force every flag bit high without a reset
    wr(ADDR_MAIN, 32'hff);
    wr(ADDR_EXTRA, 32'hff);
    bus(1'b1, ADDR_MAIN, 32'h00, 4'he);
    wr(4'h3, 32'h0);
    main_m = 8'hff;
    check_all();
    compare_val("wv pulses", 0, wv_seen);
    $display("test firmware writes done");
    // Every cause but the window violation (bit 5) over a random flag image, twice
    repeat (2) for (int i = 0; i < 9; i++) if (i != 5) begin
      d = $urandom;
      wr(ADDR_MAIN, d);
      wr(ADDR_EXTRA, d);
      main_m = d[7:0];
      extra_m = d[1];
      strobe(i);
      check_all();
      wr(ADDR_IRQ_STATUS, 32'h1ff);
      stat_m = 9'h000;
    end
    $display("test cause strobes done");
    // All four arming/open combinations of a watchdog clear
    for (int k = 0; k < 4; k++) begin
      armed <= k[1];
      wopen <= k[0];
      wd_clear <= 1'b1;
      @(posedge clock_i);
      wd_clear <= 1'b0;
      repeat (3) @(posedge clock_i);
      if (k != 3) begin main_m[5] = 1'b0; stat_m[5] = 1'b1; wv_exp++; end
      check_all();
    end
    compare_val("wv pulses", wv_exp, wv_seen);
    $display("test window violation done");
    // Status bit 5 pending: mask decides the level
    irq_chk(1'b0);
    wr(ADDR_IRQ_MASK, 32'h020);
    irq_chk(1'b1);
    rd(ADDR_IRQ_MASK, 32'h020);
    wr(ADDR_IRQ_MASK, 32'h1df);
    irq_chk(1'b0);
    wr(ADDR_IRQ_MASK, 32'h1ff);
    wr(ADDR_IRQ_STATUS, 32'h020);
    stat_m = 9'h000;
    irq_chk(1'b0);
    rd(ADDR_IRQ_STATUS, 32'h0);
    $display("test interrupt done");
    // Bus reset in mid-run must not touch the flags
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    check_all();
    irq_chk(1'b0);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
